// ===== rtl/rpd_pkg.sv
package rpd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices (byte address = index * 4)
  localparam logic [5:0]  IDX_CTRL        = 6'h00;
  localparam logic [5:0]  IDX_ALARM       = 6'h01;
  localparam logic [5:0]  IDX_STATUS      = 6'h02;
  localparam logic [5:0]  IDX_IRQ_CLR     = 6'h03;
  localparam logic [5:0]  IDX_IRQ_EN      = 6'h04;
  localparam logic [5:0]  IDX_TRIM        = 6'h12;

  ////////////////////////////////////////////////////////////////////////////
  // control register field positions
  localparam int          CTRL_W          = 13;
  localparam int          B_FREEZE        = 0;
  localparam int          B_OSC_FAIL      = 1;
  localparam int          B_CD_ENABLE     = 2;
  localparam int          B_CD_PULSE      = 3;
  localparam int          B_CD_IRQ_EN     = 4;
  localparam int          B_CD_SEL_LO     = 5;
  localparam int          B_CD_SEL_HI     = 6;
  localparam int          B_RATE0         = 7;
  localparam int          B_RATE_UP_LSB   = 8;
  localparam int          B_TRIM_SEL      = 11;
  localparam int          B_AL2_ENABLE    = 12;

  // alarm register: first repeat bits 4:0, second repeat bits 12:8
  localparam int          ALARM_W         = 13;
  localparam int          TRIM_W          = 8;

  ////////////////////////////////////////////////////////////////////////////
  // first power-up values
  localparam logic [12:0] CTRL_RST        = 13'h00E3;
  localparam logic [12:0] ALARM_RST       = 13'h0000;
  localparam logic [7:0]  TRIM_RST        = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // status bits: interrupts in bits 1:0, trim busy in bit 8
  localparam int          IRQ_W           = 2;
  localparam int          ST_POWERUP      = 0;
  localparam int          ST_TRIM_LOADED  = 1;
  localparam int          ST_TRIM_BUSY    = 8;
  localparam logic [1:0]  IRQ_RST         = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int          CLK_KHZ         = 20000;
  localparam int          TRIM_LOAD_US    = 8000;
  localparam int          TRIM_LOAD_CYC   = (TRIM_LOAD_US * CLK_KHZ + 999) / 1000;
  localparam int          TRIM_CNT_W      = 18;

  ////////////////////////////////////////////////////////////////////////////
  // bus answers
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [0:0] {
    RPD_PU_LOAD = 1'b0,
    RPD_PU_RUN  = 1'b1
  } rpd_pu_state_t;

endpackage

// ===== rtl/rpd_trim_timer.sv
`timescale 1ns/1ps
module rpd_trim_timer #(
  parameter logic [17:0] LOAD_CYCLES = 18'(rpd_pkg::TRIM_LOAD_CYC)
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy,
  output logic      done
);

  logic [17:0] cnt;

  // done pulses LOAD_CYCLES edges after the start edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt  <= 18'h00000;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        cnt  <= 18'h00000;
      end else if (abort) begin
        busy <= 1'b0;
      end else if (busy) begin
        if (cnt == LOAD_CYCLES - 18'h00001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt + 18'h00001;
        end
      end
    end
  end

endmodule

// ===== rtl/rpd_top.sv
`timescale 1ns/1ps
// Functional notes
// - first power-up loads fixed defaults: freeze, osc fail, clock selects, rate0 set.
// - retained power-up forces freeze to 1, countdown enable to 0, keeps rest.
// - unlisted control bits have no promised power-up value; software must write them.
// - writing trim select to 1 loads factory trim and makes trim read-only.
// - with trim select 0 the trim register is plain read/write storage.
// - factory trim load takes about 8 ms; host waits before trusting it.
module rpd_top #(
  parameter int LOAD_CYCLES = rpd_pkg::TRIM_LOAD_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        retention_valid,
  input  wire logic [12:0] retained_ctrl,
  input  wire logic [12:0] retained_alarm,
  input  wire logic [7:0]  retained_trim,
  input  wire logic [7:0]  factory_trim_value,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [12:0]      ctrl_word,
  output logic [12:0]      alarm_word,
  output logic [7:0]       trim_value,
  output logic             irq
);

  rpd_pkg::rpd_pu_state_t pu_state;
  logic                   aw_held;
  logic [5:0]             aw_idx;
  logic                   w_held;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   do_write;
  logic                   wr_ctrl;
  logic                   wr_alarm;
  logic                   wr_trim;
  logic                   wr_clr;
  logic                   wr_en;
  logic                   wr_known;
  logic [12:0]            next_ctrl;
  logic [12:0]            next_alarm;
  logic [7:0]             next_trim;
  logic                   trim_start;
  logic                   trim_abort;
  logic                   trim_busy;
  logic                   trim_done;
  logic [1:0]             irq_status;
  logic [1:0]             irq_enable;
  logic [1:0]             irq_events;
  logic [5:0]             ar_idx;
  logic [31:0]            next_rdata;
  logic [1:0]             next_rresp;

  function automatic logic [12:0] merge13(input logic [12:0] old, input logic [31:0] d, input logic [3:0] s);
    merge13 = {(s[1] ? d[12:8] : old[12:8]), (s[0] ? d[7:0] : old[7:0])};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // power-up sequencing: one load cycle after reset release, then run
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pu_state <= rpd_pkg::RPD_PU_LOAD;
    end else begin
      case (pu_state)
        rpd_pkg::RPD_PU_LOAD: pu_state <= rpd_pkg::RPD_PU_RUN;
        rpd_pkg::RPD_PU_RUN:  pu_state <= rpd_pkg::RPD_PU_RUN;
        default:              pu_state <= rpd_pkg::RPD_PU_LOAD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write path: address and data taken in either order, answered after both
  assign do_write   = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl    = do_write && (aw_idx == rpd_pkg::IDX_CTRL);
  assign wr_alarm   = do_write && (aw_idx == rpd_pkg::IDX_ALARM);
  assign wr_trim    = do_write && (aw_idx == rpd_pkg::IDX_TRIM);
  assign wr_clr     = do_write && (aw_idx == rpd_pkg::IDX_IRQ_CLR);
  assign wr_en      = do_write && (aw_idx == rpd_pkg::IDX_IRQ_EN);
  assign wr_known   = wr_ctrl || wr_alarm || wr_trim || wr_clr || wr_en ||
                      (do_write && (aw_idx == rpd_pkg::IDX_STATUS));
  assign next_ctrl  = merge13(ctrl_word, w_data, w_strb);
  assign next_alarm = merge13(alarm_word, w_data, w_strb);
  assign next_trim  = w_strb[0] ? w_data[7:0] : trim_value;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= rpd_pkg::RESP_OKAY;
      aw_held       <= 1'b0;
      aw_idx        <= 6'h00;
      w_held        <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else begin
      if (pu_state == rpd_pkg::RPD_PU_LOAD) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_idx        <= s_axi_awaddr[7:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? rpd_pkg::RESP_OKAY : rpd_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits; a fresh 0->1 write of trim select starts the factory load
  assign trim_start = wr_ctrl && next_ctrl[rpd_pkg::B_TRIM_SEL] && !ctrl_word[rpd_pkg::B_TRIM_SEL];
  assign trim_abort = wr_ctrl && !next_ctrl[rpd_pkg::B_TRIM_SEL];

  // unlisted bits are not promised by the power-up sequence; zero is one legal value
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_word <= rpd_pkg::CTRL_RST;
    end else if (pu_state == rpd_pkg::RPD_PU_LOAD) begin
      if (retention_valid) begin
        ctrl_word                         <= retained_ctrl;
        ctrl_word[rpd_pkg::B_FREEZE]      <= 1'b1;
        ctrl_word[rpd_pkg::B_CD_ENABLE]   <= 1'b0;
      end else begin
        ctrl_word <= rpd_pkg::CTRL_RST;
      end
    end else if (wr_ctrl) begin
      ctrl_word <= next_ctrl;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      alarm_word <= rpd_pkg::ALARM_RST;
    end else if (pu_state == rpd_pkg::RPD_PU_LOAD) begin
      alarm_word <= retention_valid ? retained_alarm : rpd_pkg::ALARM_RST;
    end else if (wr_alarm) begin
      alarm_word <= next_alarm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // factory trim transfer; the stored value needs a long read before it lands
  rpd_trim_timer #(
    .LOAD_CYCLES (18'(LOAD_CYCLES))
  ) u_trim_timer (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .start   (trim_start),
    .abort   (trim_abort),
    .busy    (trim_busy),
    .done    (trim_done)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trim_value <= rpd_pkg::TRIM_RST;
    end else if (pu_state == rpd_pkg::RPD_PU_LOAD) begin
      trim_value <= retention_valid ? retained_trim : rpd_pkg::TRIM_RST;
    end else if (trim_done && ctrl_word[rpd_pkg::B_TRIM_SEL]) begin
      trim_value <= factory_trim_value;
    end else if (wr_trim && !ctrl_word[rpd_pkg::B_TRIM_SEL]) begin
      // writes while trim select is set are dropped, answered OKAY
      trim_value <= next_trim;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: a new event beats a clear in the same cycle
  assign irq_events = {trim_done && ctrl_word[rpd_pkg::B_TRIM_SEL], pu_state == rpd_pkg::RPD_PU_LOAD};

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= rpd_pkg::IRQ_RST;
    end else begin
      irq_status <= (irq_status & ~(wr_clr ? w_data[1:0] & {2{w_strb[0]}} : 2'h0)) | irq_events;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_enable <= rpd_pkg::IRQ_RST;
    end else if (wr_en && w_strb[0]) begin
      irq_enable <= w_data[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: data one cycle after the address is taken
  assign ar_idx = s_axi_araddr[7:2];

  always_comb begin
    next_rdata = 32'h00000000;
    next_rresp = rpd_pkg::RESP_OKAY;
    case (ar_idx)
      rpd_pkg::IDX_CTRL:    next_rdata[12:0] = ctrl_word;
      rpd_pkg::IDX_ALARM:   next_rdata[12:0] = alarm_word;
      rpd_pkg::IDX_STATUS: begin
        next_rdata[1:0]                  = irq_status;
        next_rdata[rpd_pkg::ST_TRIM_BUSY] = trim_busy;
      end
      rpd_pkg::IDX_IRQ_CLR: next_rdata = 32'h00000000;
      rpd_pkg::IDX_IRQ_EN:  next_rdata[1:0] = irq_enable;
      rpd_pkg::IDX_TRIM:    next_rdata[7:0] = trim_value;
      default:              next_rresp = rpd_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= rpd_pkg::RESP_OKAY;
    end else begin
      if (pu_state == rpd_pkg::RPD_PU_LOAD) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= next_rresp;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ===== verif/rpd_props.sv
`timescale 1ns/1ps
module rpd_props #(
  parameter int LOAD_CYCLES = 20
) (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        retention_valid,
  input wire logic [12:0] retained_ctrl,
  input wire logic [7:0]  factory_trim_value,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [12:0] ctrl_word,
  input wire logic [12:0] alarm_word,
  input wire logic [7:0]  trim_value
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  // alarm bits 7:5 have no promised value, so they are masked out
  // |=> keeps the check off the releasing edge itself, where the registers still hold reset values
  a_first_defaults: assert property ($rose(reset_n) && !retention_valid |=>
    ctrl_word == 13'h00E3 && (alarm_word & 13'h1F1F) == 13'h0000 && trim_value == 8'h00)
    else $error("first power-up defaults wrong");
  a_kept_defaults: assert property ($rose(reset_n) && retention_valid |=>
    ctrl_word == (($past(retained_ctrl) | 13'h0001) & 13'h1FFB))
    else $error("retained power-up control word wrong");
  a_freeze_boot: assert property ($rose(reset_n) |=> ctrl_word[0] && !ctrl_word[2])
    else $error("freeze or countdown enable wrong after power-up");
  a_trim_early: assert property ($rose(ctrl_word[11]) |=> $stable(trim_value) [*8])
    else $error("trim changed too soon after select");
  a_trim_load: assert property ($rose(ctrl_word[11]) ##LOAD_CYCLES ctrl_word[11] |=>
    trim_value == $past(factory_trim_value))
    else $error("factory trim not loaded on time");
  a_trim_lock: assert property (ctrl_word[11] && $past(ctrl_word[11]) && $changed(trim_value) |->
    trim_value == $past(factory_trim_value))
    else $error("locked trim took another value");
  // the held pair is committed one edge after the take, so bvalid shows one edge later still
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
    !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write answer missing");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  c_trim_sel: cover property ($rose(ctrl_word[11]));
  c_kept_boot: cover property ($rose(reset_n) && retention_valid);
  c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule

// ===== verif/rpd_host.sv
`timescale 1ns/1ps
module rpd_host (
  input  wire logic        clk_sys,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  output bit               tmo
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
  end
  ////////////////////////////////////////////////////////////////////////////
  // handshakes are judged at the negedge, where the slave's registers have
  // settled, and acted on at the following rising edge
  task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic [1:0] r);
    logic ta, tw, te;
    int   n;
    n  = 0;
    te = 1'b0;
    if (wr) begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
    end else begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
    end
    while (!te && n < 100) begin
      @(negedge clk_sys);
      n++;
      ta = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
      tw = s_axi_wvalid && s_axi_wready;
      te = wr ? s_axi_bvalid : s_axi_rvalid;
      r  = wr ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge clk_sys);
      // released payloads flip so a stale value is never mistaken for live
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
        s_axi_araddr  <= ~a;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~wd;
      end
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    tmo = tmo | !te;
    @(posedge clk_sys);
  endtask
endmodule

// ===== verif/rtc_powerup_defaults_trim_load_bench.sv
`timescale 1ns/1ps
bind rpd_top rpd_props #(.LOAD_CYCLES(LOAD_CYCLES)) i_props (.clk_sys, .reset_n, .retention_valid,
  .retained_ctrl, .factory_trim_value, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ctrl_word, .alarm_word, .trim_value);
module rtc_powerup_defaults_trim_load_bench;
  localparam int LC = 20;
  logic        clk_sys            = 1'b0;
  logic        reset_n            = 1'b0;
  logic        retention_valid    = 1'b0;
  // retained inputs stay busy so a first power-up shows it ignores them
  logic [12:0] retained_ctrl      = 13'h1714;
  logic [12:0] retained_alarm     = 13'h1F1F;
  logic [7:0]  retained_trim      = 8'h5A;
  logic [7:0]  factory_trim_value = 8'hC3;
  wire  [31:0] s_axi_wdata, s_axi_rdata;
  wire  [12:0] ctrl_word, alarm_word;
  wire  [7:0]  s_axi_awaddr, s_axi_araddr, trim_value;
  wire  [3:0]  s_axi_wstrb;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, tmo;
  int          n_errors           = 0;
  int          cmp_count          = 0;
  always #25 clk_sys = ~clk_sys;
  rpd_top #(.LOAD_CYCLES(LC)) i_dut (.clk_sys, .reset_n, .retention_valid, .retained_ctrl, .retained_alarm,
    .retained_trim, .factory_trim_value, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctrl_word,
    .alarm_word, .trim_value, .irq);
  rpd_host i_host (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tmo);
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0]  r;
    i_host.xfer(wr, a, d, rd, r);
    if (tmo) begin
      $display("MISMATCH bus_wait exp done got timeout");
      n_errors++;
      final_report();
    end
    chk("resp", {30'h0, er}, {30'h0, r});
    if (!wr) chk("rdata", d, rd);
  endtask
  task automatic irq_is(input logic e);
    @(negedge clk_sys);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge clk_sys);
  endtask
  task automatic boot(input logic kept);
    reset_n         <= 1'b0;
    retention_valid <= kept;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_first();
    boot(1'b0);
    chk("ctrl", 32'h00E3, {19'h0, ctrl_word});
    chk("alarm", 32'h0, {19'h0, alarm_word & 13'h1F1F});
    chk("trim", 32'h0, {24'h0, trim_value});
    @(posedge clk_sys);
    bus(1'b0, 8'h00, 32'h0000_00E3, 2'h0);
    $display("test first_powerup done");
  endtask
  task automatic t_kept();
    boot(1'b1);
    chk("ctrl", 32'h1711, {19'h0, ctrl_word});
    chk("alarm", 32'h1F1F, {19'h0, alarm_word});
    chk("trim", 32'h5A, {24'h0, trim_value});
    @(posedge clk_sys);
    $display("test retained_powerup done");
  endtask
  task automatic t_map();
    bus(1'b1, 8'h48, 32'h0000_00A5, 2'h0);
    bus(1'b0, 8'h48, 32'h0000_00A5, 2'h0);
    bus(1'b1, 8'hFC, 32'hFFFF_FFFF, 2'h2);
    bus(1'b0, 8'hFC, 32'h0000_0000, 2'h2);
    bus(1'b1, 8'h08, 32'hFFFF_FFFF, 2'h0);
    bus(1'b0, 8'h08, 32'h0000_0001, 2'h0);
    bus(1'b0, 8'h0C, 32'h0000_0000, 2'h0);
    bus(1'b1, 8'h04, 32'h0000_0A15, 2'h0);
    bus(1'b0, 8'h04, 32'h0000_0A15, 2'h0);
    $display("test register_map done");
  endtask
  task automatic t_load();
    int n;
    n = 0;
    bus(1'b1, 8'h10, 32'h0000_0002, 2'h0);
    bus(1'b1, 8'h00, 32'h0000_1F11, 2'h0);
    bus(1'b0, 8'h08, 32'h0000_0101, 2'h0);
    do begin
      @(negedge clk_sys);
      n++;
    end while (n < 40 && trim_value !== 8'hC3);
    // the load must not land well before the programmed delay
    chk("load_wait", 32'h1, {31'h0, n >= LC - 8 && n <= LC});
    // a load that never came has already been counted above
    if (n >= 40) final_report();
    @(posedge clk_sys);
    irq_is(1'b1);
    chk("trim", 32'hC3, {24'h0, trim_value});
    bus(1'b1, 8'h48, 32'h0000_0011, 2'h0);
    bus(1'b0, 8'h48, 32'h0000_00C3, 2'h0);
    bus(1'b1, 8'h0C, 32'h0000_0002, 2'h0);
    irq_is(1'b0);
    bus(1'b1, 8'h10, 32'h0000_0001, 2'h0);
    irq_is(1'b1);
    bus(1'b1, 8'h10, 32'h0000_0000, 2'h0);
    irq_is(1'b0);
    bus(1'b1, 8'h0C, 32'h0000_0001, 2'h0);
    bus(1'b1, 8'h10, 32'h0000_0001, 2'h0);
    irq_is(1'b0);
    bus(1'b1, 8'h00, 32'h0000_1711, 2'h0);
    bus(1'b1, 8'h48, 32'h0000_0077, 2'h0);
    bus(1'b0, 8'h48, 32'h0000_0077, 2'h0);
    $display("test trim_load done");
  endtask
  initial begin
    t_first();
    t_kept();
    t_map();
    t_load();
    final_report();
  end
endmodule
